/* acb_defs.svh */
// Purpose: Offsets, field positions, reset values and counts of the aux register bank
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef ACB_DEFS_SVH
`define ACB_DEFS_SVH
`define ACB_ADDR_FLAGS    8'hA1
`define ACB_ADDR_PTRSEL   8'hA2
`define ACB_ADDR_BUSCLK   8'hA3
`define ACB_ADDR_PINSEL   8'hA4
`define ACB_PAGE_PIN0     4'h0
`define ACB_PAGE_PIN1     4'h1
`define ACB_RST_REG       8'h00
`define ACB_PTRSEL_WMASK  8'h31
`define ACB_BUSCLK_WMASK  8'hCF
`define ACB_BIT_PWM_BREAK_FLAG      4
`define ACB_BIT_M1F       3
`define ACB_BIT_M0F       2
`define ACB_BIT_START     7
`define ACB_BIT_STOP      6
`define ACB_BIT_T1RATE    3
`define ACB_BIT_T0RATE    2
`define ACB_BIT_T1CKO     1
`define ACB_BIT_T0CKO     0
`define ACB_BIT_T0SRC     0
`define ACB_BIT_DPSEL     0
`define ACB_BIT_SER0      3
`define ACB_BIT_C1OE      3
`define ACB_BIT_C1FLT     2
`define ACB_BIT_C0OE      1
`define ACB_BIT_C0FLT     0
`define ACB_PRESCALE_LAST 4'hB
`define ACB_BEEP_W        5
`endif

/* acb_pkg.sv */
// Purpose: Shared types of the aux register bank
// Assumes: Nothing beyond the language
// Notes:   Offsets live in acb_defs.svh
package acb_pkg;
  typedef logic [1:0] acb_sel2_t;
  typedef logic [7:0] acb_byte_t;
  typedef enum logic [2:0] {ACB_NONE, ACB_FLAGS, ACB_PTRSEL, ACB_BUSCLK, ACB_PIN0,
                            ACB_PIN1} acb_reg_t;
endpackage

/* acb_irq_if.sv */
// Purpose: Carrier between the bank and an external interrupt conditioner
// Assumes: One clock domain
// Notes:   Polarity in, conditioned level and edge out
`timescale 1ns/1ns
`default_nettype none
interface acb_irq_if;
  logic pol;
  logic active;
  logic edge_hit;
  modport bank (output pol, input active, input edge_hit);
  modport cond (input pol, output active, output edge_hit);
endinterface
`default_nettype wire

/* acb_irq_cond.sv */
// Purpose: Synchronise an external interrupt pin and apply its polarity
// Assumes: Pin is asynchronous to i_clk
// Notes:   Change accepted once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module acb_irq_cond (
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  input  wire logic  i_pin,
  acb_irq_if.cond    irq
);
  logic [2:0] sync_q, sync_d;
  logic       filt_q, filt_d;
  logic       act_q, act_d;
  logic       edge_q, edge_d;

  always_comb begin
    sync_d = {sync_q[1:0], i_pin};
    filt_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : filt_q;
    // Polarity 0 means low level or falling edge
    act_d  = irq.pol ? filt_d : ~filt_d;
    edge_d = (filt_d != filt_q) && (filt_d == irq.pol);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync_q <= 3'h7;
      filt_q <= 1'b1;
      act_q  <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      filt_q <= filt_d;
      act_q  <= act_d;
      edge_q <= edge_d;
    end
  end

  assign irq.active   = act_q;
  assign irq.edge_hit = edge_q;
endmodule
`default_nettype wire

/* acb_divider.sv */
// Purpose: Beeper divider on the low RC oscillator
// Assumes: Oscillator far slower than i_clk
// Notes:   Oscillator sampled as a pin, three stages
`timescale 1ns/1ns
`default_nettype none
`include "acb_defs.svh"
module acb_divider (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_osc,
  input  wire acb_pkg::acb_sel2_t i_sel,
  output logic                   o_beep
);
  import acb_pkg::*;
  logic [2:0]              sync_q, sync_d;
  logic                    lvl_q, lvl_d;
  logic [`ACB_BEEP_W-1:0]  cnt_q, cnt_d;
  logic                    beep_q, beep_d;

  always_comb begin
    sync_d = {sync_q[1:0], i_osc};
    lvl_d  = (sync_q[2] == sync_q[1]) ? sync_q[2] : lvl_q;
    cnt_d  = cnt_q;
    if (lvl_d && !lvl_q) begin
      cnt_d = cnt_q + `ACB_BEEP_W'(1);
    end
    // Counter bit n toggles every 2^n rising oscillator edges
    case (i_sel)
      2'h1:    beep_d = cnt_q[4];
      2'h2:    beep_d = cnt_q[3];
      2'h3:    beep_d = cnt_q[2];
      default: beep_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync_q <= 3'h0;
      lvl_q  <= 1'b0;
      cnt_q  <= '0;
      beep_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
      cnt_q  <= cnt_d;
      beep_q <= beep_d;
    end
  end

  assign o_beep = beep_q;
endmodule
`default_nettype wire

/* acb_aux_regs.sv */
// Purpose: Auxiliary special-function register bank with flags, polarity and pin routing
// Assumes: One system clock, synchronous active-low reset, SFR port on the same clock
// Notes:   Routing fields leave this block as codes; port muxes sit elsewhere
`timescale 1ns/1ns
`default_nettype none
`include "acb_defs.svh"
// Summary of operation
// - On internal clock, pin 6.0 field picks GPIO, clock, clock/2 or clock/4.
// - On external clock input, pin 6.0 stays clock input; field ignored.
// - Break flag set by source or software; blocks PWM 0-5; software clears.
// - Second modulator flag set by its switch event; held until software clears.
// - First modulator flag set by its switch event; held until software clears.
// - Interrupt 1 polarity: 0 low or falling, 1 high or rising.
// - Interrupt 0 polarity: 0 low or falling, 1 high or rising.
// - Pointer select bit: 0 first data pointer, 1 second.
// - Start condition sets start flag; firmware clears by writing zero.
// - Stop condition sets stop flag; firmware clears by writing zero.
// - Timer clock-rate bit: 0 counts clock/12, 1 counts raw clock.
// - Extra timer 0 source bit acts like the timer 0 rate bit.
// - Timer clock-out enables drive each timer clock-out pin.
// - Timer 0 pin field routes input and clock-out among four pins.
// - Beeper field: pin 4.4 GPIO or slow oscillator /32, /16, /8.
// - Serial 0 pin pair follows two bits, upper bit from elsewhere.
// - Two-wire pin field maps clock and data to four pin pairs.
// - Timer 2 pin field maps clock-out and trigger to four pin pairs.
// - Timer 1 pin field routes input and clock-out among four pins.
// - Comparator output enables put results on their fixed pins.
// - Address 0xA4 banked: page 0 pin register, page 1 timer/comparator register.
module acb_aux_regs (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic [7:0]         i_sfr_addr,
  input  wire logic [3:0]         i_sfr_page,
  input  wire logic               i_sfr_wr,
  input  wire logic               i_sfr_rd,
  input  wire acb_pkg::acb_byte_t i_sfr_wdata,
  output acb_pkg::acb_byte_t      o_sfr_rdata,
  output logic                    o_sfr_hit,
  input  wire logic               i_pwm_break_event,
  input  wire logic               i_mod0_event,
  input  wire logic               i_mod1_event,
  input  wire logic               i_bus_start_event,
  input  wire logic               i_bus_stop_event,
  input  wire logic               i_ext_irq0_pin,
  input  wire logic               i_ext_irq1_pin,
  input  wire logic               i_ext_clock_mode,
  input  wire logic               i_serial0_pin_hi,
  input  wire logic               i_low_osc,
  input  wire logic               i_cmp0_result,
  input  wire logic               i_cmp1_result,
  output logic                    o_ext_irq0_active,
  output logic                    o_ext_irq0_edge,
  output logic                    o_ext_irq1_active,
  output logic                    o_ext_irq1_edge,
  output logic                    o_data_pointer_select,
  output acb_pkg::acb_sel2_t      o_crc_port_select,
  output logic                    o_pwm_block,
  output acb_pkg::acb_sel2_t      o_pin60_function,
  output logic                    o_pin60_clk_div,
  output logic                    o_pin60_fast_drive,
  output logic                    o_timer0_tick,
  output logic                    o_timer1_tick,
  output logic                    o_timer0_clock_out_enable,
  output logic                    o_timer1_clock_out_enable,
  output acb_pkg::acb_sel2_t      o_timer0_pin_select,
  output acb_pkg::acb_sel2_t      o_timer1_pin_select,
  output acb_pkg::acb_sel2_t      o_timer2_pin_select,
  output acb_pkg::acb_sel2_t      o_beeper_control,
  output logic                    o_beeper_out,
  output acb_pkg::acb_sel2_t      o_serial0_pin_select,
  output acb_pkg::acb_sel2_t      o_two_wire_pin_select,
  output logic                    o_cmp0_pin,
  output logic                    o_cmp0_pin_oe,
  output logic                    o_cmp1_pin,
  output logic                    o_cmp1_pin_oe,
  output logic                    o_cmp0_filter_control,
  output logic                    o_cmp1_filter_control
);
  import acb_pkg::*;

  function automatic acb_reg_t reg_decode(input logic [7:0] addr, input logic [3:0] page);
    acb_reg_t r;
    r = ACB_NONE;
    if (addr == `ACB_ADDR_FLAGS) begin
      r = ACB_FLAGS;
    end else if (addr == `ACB_ADDR_PTRSEL) begin
      r = ACB_PTRSEL;
    end else if (addr == `ACB_ADDR_BUSCLK) begin
      r = ACB_BUSCLK;
    end else if (addr == `ACB_ADDR_PINSEL && page == `ACB_PAGE_PIN0) begin
      r = ACB_PIN0;
    end else if (addr == `ACB_ADDR_PINSEL && page == `ACB_PAGE_PIN1) begin
      r = ACB_PIN1;
    end
    return r;
  endfunction

  acb_reg_t  wsel, rsel;
  acb_byte_t flags_q, flags_d;
  acb_byte_t ptrsel_q, ptrsel_d;
  acb_byte_t busclk_q, busclk_d;
  acb_byte_t pin0_q, pin0_d;
  acb_byte_t pin1_q, pin1_d;
  acb_byte_t rdata_q, rdata_d;
  logic      hit_q, hit_d;
  logic [3:0] pre_q, pre_d;
  logic       t0_tick_q, t0_tick_d;
  logic       t1_tick_q, t1_tick_d;
  logic [1:0] mck_cnt_q, mck_cnt_d;
  acb_sel2_t  p60_fn_q, p60_fn_d;
  logic       p60_div_q, p60_div_d;
  acb_sel2_t  ser_sel_q, ser_sel_d;
  logic       c0_pin_q, c0_pin_d;
  logic       c0_oe_q, c0_oe_d;
  logic       c1_pin_q, c1_pin_d;
  logic       c1_oe_q, c1_oe_d;
  logic       pre_wrap;
  logic       t0_fast;

  assign wsel = i_sfr_wr ? reg_decode(i_sfr_addr, i_sfr_page) : ACB_NONE;
  assign rsel = reg_decode(i_sfr_addr, i_sfr_page);

  // Register writes; hardware set beats a same-cycle software clear
  always_comb begin
    flags_d  = flags_q;
    ptrsel_d = ptrsel_q;
    busclk_d = busclk_q;
    pin0_d   = pin0_q;
    pin1_d   = pin1_q;
    if (wsel == ACB_FLAGS) begin
      flags_d = i_sfr_wdata;
    end
    if (wsel == ACB_PTRSEL) begin
      // Reserved bits are dropped even if software breaks the zero convention
      ptrsel_d = i_sfr_wdata & `ACB_PTRSEL_WMASK;
    end
    if (wsel == ACB_BUSCLK) begin
      busclk_d = i_sfr_wdata & `ACB_BUSCLK_WMASK;
    end
    if (wsel == ACB_PIN0) begin
      pin0_d = i_sfr_wdata;
    end
    if (wsel == ACB_PIN1) begin
      pin1_d = i_sfr_wdata;
    end
    flags_d[`ACB_BIT_PWM_BREAK_FLAG]  = flags_d[`ACB_BIT_PWM_BREAK_FLAG] | i_pwm_break_event;
    flags_d[`ACB_BIT_M1F]   = flags_d[`ACB_BIT_M1F] | i_mod1_event;
    flags_d[`ACB_BIT_M0F]   = flags_d[`ACB_BIT_M0F] | i_mod0_event;
    busclk_d[`ACB_BIT_START] = busclk_d[`ACB_BIT_START] | i_bus_start_event;
    busclk_d[`ACB_BIT_STOP]  = busclk_d[`ACB_BIT_STOP] | i_bus_stop_event;
  end

  // Registered read data; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    hit_d   = 1'b0;
    if (i_sfr_rd) begin
      hit_d = (rsel != ACB_NONE);
      if (rsel == ACB_FLAGS) begin
        rdata_d = flags_q;
      end else if (rsel == ACB_PTRSEL) begin
        rdata_d = ptrsel_q;
      end else if (rsel == ACB_BUSCLK) begin
        rdata_d = busclk_q;
      end else if (rsel == ACB_PIN0) begin
        rdata_d = pin0_q;
      end else if (rsel == ACB_PIN1) begin
        rdata_d = pin1_q;
      end else begin
        rdata_d = `ACB_RST_REG;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      flags_q  <= `ACB_RST_REG;
      ptrsel_q <= `ACB_RST_REG;
      busclk_q <= `ACB_RST_REG;
      pin0_q   <= `ACB_RST_REG;
      pin1_q   <= `ACB_RST_REG;
      rdata_q  <= `ACB_RST_REG;
      hit_q    <= 1'b0;
    end else begin
      flags_q  <= flags_d;
      ptrsel_q <= ptrsel_d;
      busclk_q <= busclk_d;
      pin0_q   <= pin0_d;
      pin1_q   <= pin1_d;
      rdata_q  <= rdata_d;
      hit_q    <= hit_d;
    end
  end

  // Timer ticks, pin 6.0 clock, pin routing and comparator outputs
  assign pre_wrap = (pre_q == `ACB_PRESCALE_LAST);
  assign t0_fast  = busclk_q[`ACB_BIT_T0RATE] | pin0_q[`ACB_BIT_T0SRC];

  always_comb begin
    pre_d     = pre_wrap ? 4'h0 : pre_q + 4'h1;
    t1_tick_d = busclk_q[`ACB_BIT_T1RATE] ? 1'b1 : pre_wrap;
    t0_tick_d = t0_fast ? 1'b1 : pre_wrap;
    mck_cnt_d = mck_cnt_q + 2'h1;
    // External clock owns the pin regardless of the field
    p60_fn_d  = i_ext_clock_mode ? 2'h0 : flags_q[7:6];
    case (p60_fn_d)
      2'h2:    p60_div_d = mck_cnt_q[0];
      2'h3:    p60_div_d = mck_cnt_q[1];
      default: p60_div_d = 1'b0;
    endcase
    ser_sel_d = {i_serial0_pin_hi, pin0_q[`ACB_BIT_SER0]};
    c0_oe_d   = pin1_q[`ACB_BIT_C0OE];
    c0_pin_d  = pin1_q[`ACB_BIT_C0OE] & i_cmp0_result;
    c1_oe_d   = pin1_q[`ACB_BIT_C1OE];
    c1_pin_d  = pin1_q[`ACB_BIT_C1OE] & i_cmp1_result;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pre_q     <= 4'h0;
      t0_tick_q <= 1'b0;
      t1_tick_q <= 1'b0;
      mck_cnt_q <= 2'h0;
      p60_fn_q  <= 2'h0;
      p60_div_q <= 1'b0;
      ser_sel_q <= 2'h0;
      c0_pin_q  <= 1'b0;
      c0_oe_q   <= 1'b0;
      c1_pin_q  <= 1'b0;
      c1_oe_q   <= 1'b0;
    end else begin
      pre_q     <= pre_d;
      t0_tick_q <= t0_tick_d;
      t1_tick_q <= t1_tick_d;
      mck_cnt_q <= mck_cnt_d;
      p60_fn_q  <= p60_fn_d;
      p60_div_q <= p60_div_d;
      ser_sel_q <= ser_sel_d;
      c0_pin_q  <= c0_pin_d;
      c0_oe_q   <= c0_oe_d;
      c1_pin_q  <= c1_pin_d;
      c1_oe_q   <= c1_oe_d;
    end
  end

  // Interrupt pin conditioning, one per external interrupt
  acb_irq_if irq [2] ();
  logic [1:0] irq_pin;
  logic [1:0] irq_act;
  logic [1:0] irq_edge;
  assign irq_pin = {i_ext_irq1_pin, i_ext_irq0_pin};

  for (genvar g = 0; g < 2; g++) begin : g_irq
    assign irq[g].pol = flags_q[g];
    assign irq_act[g]  = irq[g].active;
    assign irq_edge[g] = irq[g].edge_hit;
    acb_irq_cond u_cond (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (irq_pin[g]),
      .irq      (irq[g])
    );
  end

  acb_divider u_beep (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_osc    (i_low_osc),
    .i_sel    (pin0_q[5:4]),
    .o_beep   (o_beeper_out)
  );

  assign o_sfr_rdata               = rdata_q;
  assign o_sfr_hit                 = hit_q;
  assign o_ext_irq0_active         = irq_act[0];
  assign o_ext_irq0_edge           = irq_edge[0];
  assign o_ext_irq1_active         = irq_act[1];
  assign o_ext_irq1_edge           = irq_edge[1];
  assign o_data_pointer_select     = ptrsel_q[`ACB_BIT_DPSEL];
  assign o_crc_port_select         = ptrsel_q[5:4];
  assign o_pwm_block               = flags_q[`ACB_BIT_PWM_BREAK_FLAG];
  assign o_pin60_function          = p60_fn_q;
  assign o_pin60_clk_div           = p60_div_q;
  assign o_pin60_fast_drive        = flags_q[5];
  assign o_timer0_tick             = t0_tick_q;
  assign o_timer1_tick             = t1_tick_q;
  assign o_timer0_clock_out_enable = busclk_q[`ACB_BIT_T0CKO];
  assign o_timer1_clock_out_enable = busclk_q[`ACB_BIT_T1CKO];
  assign o_timer0_pin_select       = pin0_q[7:6];
  assign o_timer1_pin_select       = pin1_q[5:4];
  assign o_timer2_pin_select       = pin1_q[7:6];
  assign o_beeper_control          = pin0_q[5:4];
  assign o_serial0_pin_select      = ser_sel_q;
  assign o_two_wire_pin_select     = pin0_q[2:1];
  assign o_cmp0_pin                = c0_pin_q;
  assign o_cmp0_pin_oe             = c0_oe_q;
  assign o_cmp1_pin                = c1_pin_q;
  assign o_cmp1_pin_oe             = c1_oe_q;
  assign o_cmp0_filter_control     = pin1_q[`ACB_BIT_C0FLT];
  assign o_cmp1_filter_control     = pin1_q[`ACB_BIT_C1FLT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_break_seen;
    i_pwm_break_event ##1 o_pwm_block;
  endsequence
  property p_break_blocks;
    i_pwm_break_event |-> s_break_seen;
  endproperty
  a_break_blocks: assert property (p_break_blocks) else $error("break did not block");

  property p_mod1_flag;
    i_mod1_event |=> flags_q[`ACB_BIT_M1F];
  endproperty
  a_mod1_flag: assert property (p_mod1_flag) else $error("mod1 flag lost");

  property p_mod0_hold;
    flags_q[`ACB_BIT_M0F] && wsel != ACB_FLAGS |=> flags_q[`ACB_BIT_M0F];
  endproperty
  a_mod0_hold: assert property (p_mod0_hold) else $error("mod0 flag dropped");

  property p_start_flag;
    i_bus_start_event |=> busclk_q[`ACB_BIT_START];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("start flag lost");

  property p_stop_flag;
    i_bus_stop_event |=> busclk_q[`ACB_BIT_STOP];
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop flag lost");

  property p_ext_clk_pin;
    i_ext_clock_mode |=> o_pin60_function == 2'h0 && !o_pin60_clk_div;
  endproperty
  a_ext_clk_pin: assert property (p_ext_clk_pin) else $error("pin 6.0 left clock input");

  property p_dptr_write;
    wsel == ACB_PTRSEL |=> o_data_pointer_select == $past(i_sfr_wdata[0])
                          && ptrsel_q[3:1] == 3'h0;
  endproperty
  a_dptr_write: assert property (p_dptr_write) else $error("pointer select wrong");

  property p_t1_slow;
    (!busclk_q[`ACB_BIT_T1RATE] && t1_tick_q && pre_q == 4'h0)
      ##1 !busclk_q[`ACB_BIT_T1RATE] [*8] |-> !t1_tick_q;
  endproperty
  a_t1_slow: assert property (p_t1_slow) else $error("timer1 slow tick too early");

  property p_page_bank;
    wsel == ACB_PIN1 |=> pin0_q == $past(pin0_q);
  endproperty
  a_page_bank: assert property (p_page_bank) else $error("page 1 write hit page 0");

  property p_cmp_off;
    !pin1_q[`ACB_BIT_C0OE] |=> !o_cmp0_pin_oe && !o_cmp0_pin;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("comparator 0 drove while off");
endmodule
`default_nettype wire

/* aux_control_register_bank_test.sv */
// Purpose: Self-checking bench for the aux register bank
// Assumes: acb_pkg, acb_irq_if and the design modules compiled first
// Notes:   Read data is checked through a queue of expected bytes
`timescale 1ns/1ns
`default_nettype none
module aux_control_register_bank_test;
  import acb_pkg::*;
  logic       i_clk, i_resetn, i_sfr_wr, i_sfr_rd;
  logic [7:0] i_sfr_addr;
  logic [3:0] i_sfr_page;
  acb_byte_t  i_sfr_wdata, o_sfr_rdata, r, n;
  logic [4:0] evt;
  logic       o_sfr_hit, i_pwm_break_event, i_mod0_event, i_mod1_event;
  logic       i_bus_start_event, i_bus_stop_event, i_ext_irq0_pin, i_ext_irq1_pin;
  logic       i_ext_clock_mode, i_serial0_pin_hi, i_low_osc, i_cmp0_result, i_cmp1_result;
  logic       o_ext_irq0_active, o_ext_irq0_edge, o_ext_irq1_active, o_ext_irq1_edge;
  logic       o_data_pointer_select, o_pwm_block, o_pin60_clk_div, o_pin60_fast_drive;
  logic       o_timer0_tick, o_timer1_tick, o_timer0_clock_out_enable, o_beeper_out;
  logic       o_timer1_clock_out_enable, o_cmp0_pin, o_cmp0_pin_oe, o_cmp1_pin;
  logic       o_cmp1_pin_oe, o_cmp0_filter_control, o_cmp1_filter_control;
  acb_sel2_t  o_crc_port_select, o_pin60_function, o_timer0_pin_select, o_timer1_pin_select;
  acb_sel2_t  o_timer2_pin_select, o_beeper_control, o_serial0_pin_select;
  acb_sel2_t  o_two_wire_pin_select;
  acb_byte_t  exp_q[$];
  int         miscompares, samples_checked, seed;

  // Event pulses share one vector so a single task can fire any of them
  assign {i_bus_stop_event, i_mod1_event, i_mod0_event, i_bus_start_event,
          i_pwm_break_event} = evt;

  acb_aux_regs i_dut (.*);

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr  <= a;
    i_sfr_page  <= p;
    i_sfr_wdata <= d;
    i_sfr_wr    <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr    <= 1'b0;
  endtask

  // Mapped reads leave a note for the monitor; unmapped ones are checked here
  task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e,
                    input bit mapped);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_page <= p;
    i_sfr_rd   <= 1'b1;
    if (mapped)
      exp_q.push_back(e);
    @(posedge i_clk);
    i_sfr_rd   <= 1'b0;
    @(negedge i_clk);
    if (!mapped)
      chk("unmapped_rdata", 8'h00, o_sfr_rdata);
  endtask

  task automatic pulse(input int k);
    @(posedge i_clk);
    evt[k] <= 1'b1;
    @(posedge i_clk);
    evt    <= 5'h00;
  endtask

  task automatic ticks(input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] c0, c1;
    c0 = 8'h00;
    c1 = 8'h00;
    repeat (2) @(posedge i_clk);
    repeat (24) begin
      @(negedge i_clk);
      c0 += {7'h00, o_timer0_tick === 1'b1};
      c1 += {7'h00, o_timer1_tick === 1'b1};
    end
    chk("timer0_ticks", e0, c0);
    chk("timer1_ticks", e1, c1);
  endtask

  task automatic end_of_test;
    if (exp_q.size() != 0)
      miscompares++;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read data stands one cycle after the read edge; sample it mid-cycle
  always @(negedge i_clk) begin
    if (o_sfr_hit === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("Error sfr_hit expected 0 seen 1");
        miscompares++;
      end else
        chk("sfr_rdata", exp_q.pop_front(), o_sfr_rdata);
    end
  end

  // Hang guard, far above the length of the main sequence
  initial begin
    repeat (20000) @(posedge i_clk);
    $display("Error timeout expected done seen hang");
    miscompares++;
    end_of_test();
  end

  initial begin
    i_resetn = 1'b0;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_page = 4'h0;
    i_sfr_wdata = 8'h00;
    evt = 5'h00;
    i_ext_irq0_pin = 1'b1;
    i_ext_irq1_pin = 1'b1;
    i_ext_clock_mode = 1'b0;
    i_serial0_pin_hi = 1'b1;
    i_low_osc = 1'b0;
    i_cmp0_result = 1'b1;
    i_cmp1_result = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    seed = $urandom(32'h3058);
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(8'hA1, 4'h0, 8'h00, 1'b1);
    rd(8'hA2, 4'h0, 8'h00, 1'b1);
    rd(8'hA3, 4'h0, 8'h00, 1'b1);
    rd(8'hA4, 4'h0, 8'h00, 1'b1);
    rd(8'hA4, 4'h1, 8'h00, 1'b1);
    rd(8'hA0, 4'h0, 8'h00, 1'b0);
    rd(8'hA4, 4'h2, 8'h00, 1'b0);
    $display("test reset done");
    r = acb_byte_t'($urandom);
    wr(8'hA4, 4'h0, r);
    wr(8'hA4, 4'h1, ~r);
    wr(8'hA4, 4'h2, 8'hFF);
    rd(8'hA4, 4'h0, r, 1'b1);
    rd(8'hA4, 4'h1, ~r, 1'b1);
    chk("timer0_pin", {6'h00, r[7:6]}, {6'h00, o_timer0_pin_select});
    chk("beeper", {6'h00, r[5:4]}, {6'h00, o_beeper_control});
    chk("serial0_pin", {6'h00, 1'b1, r[3]}, {6'h00, o_serial0_pin_select});
    chk("two_wire_pin", {6'h00, r[2:1]}, {6'h00, o_two_wire_pin_select});
    chk("timer2_pin", {6'h00, ~r[7:6]}, {6'h00, o_timer2_pin_select});
    chk("timer1_pin", {6'h00, ~r[5:4]}, {6'h00, o_timer1_pin_select});
    chk("cmp_filter", {6'h00, ~r[2], ~r[0]},
        {6'h00, o_cmp1_filter_control, o_cmp0_filter_control});
    // Reserved bits written as zero, as software must
    wr(8'hA2, 4'h0, 8'h31);
    rd(8'hA2, 4'h0, 8'h31, 1'b1);
    chk("dptr_select", 8'h01, {7'h00, o_data_pointer_select});
    chk("crc_port", 8'h03, {6'h00, o_crc_port_select});
    wr(8'hA2, 4'h0, 8'h00);
    @(negedge i_clk);
    chk("dptr_select", 8'h00, {7'h00, o_data_pointer_select});
    $display("test masks done");
    wr(8'hA4, 4'h0, 8'h00);
    wr(8'hA3, 4'h0, 8'h3F);
    rd(8'hA3, 4'h0, 8'h0F, 1'b1);
    chk("clock_out_en", 8'h03,
        {6'h00, o_timer1_clock_out_enable, o_timer0_clock_out_enable});
    ticks(8'd24, 8'd24);
    wr(8'hA3, 4'h0, 8'h00);
    ticks(8'd2, 8'd2);
    wr(8'hA4, 4'h0, 8'h01);
    ticks(8'd24, 8'd2);
    $display("test timers done");
    wr(8'hA1, 4'h0, 8'h00);
    pulse(3);
    rd(8'hA1, 4'h0, 8'h08, 1'b1);
    pulse(2);
    rd(8'hA1, 4'h0, 8'h0C, 1'b1);
    pulse(0);
    @(negedge i_clk);
    chk("pwm_block", 8'h01, {7'h00, o_pwm_block});
    rd(8'hA1, 4'h0, 8'h1C, 1'b1);
    wr(8'hA1, 4'h0, 8'h00);
    rd(8'hA1, 4'h0, 8'h00, 1'b1);
    pulse(3);
    @(negedge i_clk);
    chk("pwm_block", 8'h00, {7'h00, o_pwm_block});
    rd(8'hA1, 4'h0, 8'h08, 1'b1);
    wr(8'hA1, 4'h0, 8'h00);
    pulse(4);
    rd(8'hA3, 4'h0, 8'h40, 1'b1);
    pulse(1);
    rd(8'hA3, 4'h0, 8'h80 | 8'h40, 1'b1);
    wr(8'hA3, 4'h0, 8'h00);
    rd(8'hA3, 4'h0, 8'h00, 1'b1);
    $display("test flags done");
    wr(8'hA1, 4'h0, 8'hA0);
    repeat (2) @(posedge i_clk);
    chk("pin60_fn", 8'h02, {6'h00, o_pin60_function});
    chk("pin60_fast", 8'h01, {7'h00, o_pin60_fast_drive});
    @(negedge i_clk);
    n = {7'h00, o_pin60_clk_div};
    @(negedge i_clk);
    chk("pin60_div", {7'h00, ~n[0]}, {7'h00, o_pin60_clk_div});
    @(posedge i_clk);
    i_ext_clock_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("pin60_fn", 8'h00, {6'h00, o_pin60_function});
    i_ext_clock_mode <= 1'b0;
    i_serial0_pin_hi <= 1'b0;
    wr(8'hA4, 4'h1, 8'h0A);
    i_cmp0_result <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("cmp_pins", 8'h0D,
        {4'h0, o_cmp1_pin, o_cmp1_pin_oe, o_cmp0_pin, o_cmp0_pin_oe});
    chk("serial0_pin", 8'h00, {6'h00, o_serial0_pin_select});
    $display("test pins done");
    wr(8'hA1, 4'h0, 8'h00);
    i_ext_irq0_pin <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("irq_active", 8'h01, {6'h00, o_ext_irq1_active, o_ext_irq0_active});
    wr(8'hA1, 4'h0, 8'h03);
    repeat (8) @(posedge i_clk);
    chk("irq_active", 8'h02, {6'h00, o_ext_irq1_active, o_ext_irq0_active});
    // Rising pin under high polarity gives exactly one edge pulse
    i_ext_irq0_pin <= 1'b1;
    n = 8'h00;
    repeat (8) begin
      @(negedge i_clk);
      n += {7'h00, o_ext_irq0_edge === 1'b1};
    end
    chk("irq0_edge", 8'h01, n);
    $display("test irq done");
    // Four oscillator rising edges set counter bit 2, the /8 tap
    wr(8'hA4, 4'h0, 8'h30);
    repeat (8) begin
      repeat (4) @(posedge i_clk);
      i_low_osc <= ~i_low_osc;
    end
    repeat (6) @(posedge i_clk);
    chk("beeper_out", 8'h01, {7'h00, o_beeper_out});
    $display("test beeper done");
    // Reset in mid-run clears a freshly set start flag and the polarity bits
    pulse(1);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(8'hA3, 4'h0, 8'h00, 1'b1);
    rd(8'hA1, 4'h0, 8'h00, 1'b1);
    $display("test reset again done");
    repeat (2) @(posedge i_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
